// *** hw/apcm_port.sv ***
/*
 * Auxiliary PCM audio port: clock master, full duplex, I2S or
 * left-justified framing, transmit FIFO in front of the serialiser.
 * Assumes the DSP sets the bit clock half period in core cycles and
 * that the far end presents input data around the rising bit clock edge.
 */
`timescale 1ns/100ps

// What this block does
// R1: Device always drives bit clock and framing
// R2: Bit clock 32, 64 or 128 Fs
// R3: Receive and transmit in the same frames
// R4: One format setting for both directions
// R5: One framing cycle per sample period
// R6: 18-bit I2S or 20-bit left-justified samples; at 32 Fs the code carries only 15 (I2S) or 16 (left-justified) bits
// R7: Framing and data change on falling edge
// R8: Input sampled on rising bit clock edge
// R9: Sample rate 16 to 48 kHz
// R10: Samples handed to and from the DSP
// R11: MSB one clock late in I2S only
// R12: Zeros out and ignored in beyond width
module apcm_port #(
   parameter int FIFO_DEPTH = apcm_pkg::FIFO_DEPTH
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic [1:0] aux_port_control_reg_in,
   input wire logic aux_format_in,
   input wire logic [apcm_pkg::DIV_W-1:0] bclk_half_in,
   input wire logic [apcm_pkg::SAMPLE_W-1:0] tx_left_in,
   input wire logic [apcm_pkg::SAMPLE_W-1:0] tx_right_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   output logic [apcm_pkg::SAMPLE_W-1:0] rx_left_out,
   output logic [apcm_pkg::SAMPLE_W-1:0] rx_right_out,
   output logic rx_valid_out,
   input wire logic aux_serial_in,
   output logic aux_bit_clock_out,
   output logic aux_frame_select_out,
   output logic aux_serial_out
);

   // ****************************************************************
   // Format helpers
   // ****************************************************************
   function automatic logic [apcm_pkg::SLOT_W-1:0] slots_of(
      input logic [1:0] rate
   );
      logic [apcm_pkg::SLOT_W-1:0] n;
      n = apcm_pkg::SLOTS_64;
      if (rate == apcm_pkg::RATE_32FS) begin
         n = apcm_pkg::SLOTS_32;
      end else if (rate == apcm_pkg::RATE_128FS) begin
         n = apcm_pkg::SLOTS_128;
      end
      return n;
   endfunction : slots_of

   // Slot to sample bit: {valid, bit index in the 20-bit word}
   function automatic logic [5:0] bit_map(
      input logic [apcm_pkg::SLOT_W-1:0] slot,
      input logic [apcm_pkg::SLOT_W-1:0] slots,
      input logic fmt
   );
      logic [apcm_pkg::SLOT_W-1:0] half;
      logic [apcm_pkg::SLOT_W-1:0] pos;
      logic [apcm_pkg::SLOT_W-1:0] k;
      logic [4:0] w;
      logic ok;
      half = slots >> 1;
      pos = (slot >= half) ? slot - half : slot;
      k = pos - apcm_pkg::SLOT_W'(fmt == apcm_pkg::FMT_I2S);
      w = (fmt == apcm_pkg::FMT_LJ) ? apcm_pkg::WIDTH_LJ :
         apcm_pkg::WIDTH_I2S;
      ok = ((fmt == apcm_pkg::FMT_LJ) || (pos != '0)) &&
         (k < {3'h0, w});
      return {ok, apcm_pkg::MSB_IDX - k[4:0]};
   endfunction : bit_map

   function automatic logic is_left(
      input logic [apcm_pkg::SLOT_W-1:0] slot,
      input logic [apcm_pkg::SLOT_W-1:0] slots
   );
      return slot < (slots >> 1);
   endfunction : is_left

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam int SW = apcm_pkg::SAMPLE_W;
   apcm_stream_if #(.W(apcm_pkg::WORD_W)) tx_s ();
   logic din_s1_r;
   logic din_s2_r;
   logic [apcm_pkg::DIV_W-1:0] div_cnt_r;
   logic [apcm_pkg::DIV_W-1:0] half_eff;
   logic tick;
   logic fall_evt;
   logic rise_evt;
   logic bclk_r;
   logic [1:0] cfg_rate_r;
   logic cfg_fmt_r;
   logic [apcm_pkg::SLOT_W-1:0] slots_cur;
   logic [apcm_pkg::SLOT_W-1:0] slots_sel;
   logic fmt_sel;
   logic [apcm_pkg::SLOT_W-1:0] slot_r;
   logic [apcm_pkg::SLOT_W-1:0] slot_nxt;
   logic load_evt;
   logic [apcm_pkg::WORD_W-1:0] new_word;
   logic [apcm_pkg::WORD_W-1:0] word_sel;
   logic [apcm_pkg::WORD_W-1:0] tx_hold_r;
   logic [5:0] tx_map;
   logic tx_left;
   logic tx_bit_nxt;
   logic lr_nxt;
   logic lr_r;
   logic dout_r;
   logic [5:0] rx_map;
   logic rx_left;
   logic [SW-1:0] rx_l_sh_r;
   logic [SW-1:0] rx_r_sh_r;
   logic [SW-1:0] cap_l;
   logic [SW-1:0] cap_r;
   logic [SW-1:0] rx_l_r;
   logic [SW-1:0] rx_rt_r;
   logic rx_valid_r;
   logic frame_end;

   // ****************************************************************
   // Transmit FIFO
   // ****************************************************************
   assign tx_s.in_valid = tx_valid_in;
   assign tx_s.in_data = {tx_left_in, tx_right_in};
   assign tx_s.out_ready = load_evt; // [R10]

   apcm_fifo #(.W(apcm_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .s(tx_s)
   );

   // ****************************************************************
   // Input synchroniser
   // ****************************************************************
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         din_s1_r <= 1'h0;
         din_s2_r <= 1'h0;
      end else begin
         din_s1_r <= aux_serial_in;
         din_s2_r <= din_s1_r;
      end
   end

   // ****************************************************************
   // Bit clock divider
   // ****************************************************************
   // DSP picks the half period for the wanted Fs and ratio [R9]
   assign half_eff = (bclk_half_in == '0) ? apcm_pkg::DIV_W'(1) :
      bclk_half_in;
   assign tick = (div_cnt_r >= half_eff - 1'b1);
   assign fall_evt = tick && bclk_r;
   assign rise_evt = tick && !bclk_r;

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div_cnt_r <= '0;
         bclk_r <= apcm_pkg::BCLK_RST;
      end else begin
         div_cnt_r <= tick ? '0 : div_cnt_r + 1'b1;
         if (tick) begin
            bclk_r <= !bclk_r; // [R1]
         end
      end
   end

   // ****************************************************************
   // Slot counter and frame configuration
   // ****************************************************************
   assign slots_cur = slots_of(cfg_rate_r);
   assign slot_nxt = (slot_r >= slots_cur - 1'b1) ? '0 : slot_r + 1'b1;
   assign load_evt = fall_evt && (slot_nxt == '0);
   // New rate and format settings take hold only at a frame boundary
   assign slots_sel = load_evt ? slots_of(aux_port_control_reg_in) :
      slots_cur; // [R2]
   assign fmt_sel = load_evt ? aux_format_in : cfg_fmt_r; // [R4]

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         slot_r <= apcm_pkg::SLOT_RST;
         cfg_rate_r <= apcm_pkg::RATE_RST;
         cfg_fmt_r <= apcm_pkg::FMT_RST;
      end else if (fall_evt) begin
         slot_r <= slot_nxt; // [R5]
         if (load_evt) begin
            cfg_rate_r <= aux_port_control_reg_in[
               apcm_pkg::CTRL_RATE_MSB:apcm_pkg::CTRL_RATE_LSB]; // [R2]
            cfg_fmt_r <= aux_format_in; // [R6]
         end
      end
   end

   // ****************************************************************
   // Transmit serialiser
   // ****************************************************************
   // Empty FIFO at frame start sends a silent frame
   assign new_word = tx_s.out_valid ? tx_s.out_data : '0;
   assign word_sel = load_evt ? new_word : tx_hold_r;
   assign tx_map = bit_map(slot_nxt, slots_sel, fmt_sel); // [R11]
   assign tx_left = is_left(slot_nxt, slots_sel);
   assign tx_bit_nxt = tx_map[5] && (tx_left ?
      word_sel[SW + int'(tx_map[4:0])] : word_sel[tx_map[4:0]]); // [R12]
   // Left is low in I2S and high in left-justified framing
   assign lr_nxt = (fmt_sel == apcm_pkg::FMT_LJ) ? tx_left : !tx_left;

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_hold_r <= '0;
      end else if (load_evt) begin
         tx_hold_r <= new_word; // [R10]
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lr_r <= 1'h0;
         dout_r <= 1'h0;
      end else if (fall_evt) begin
         lr_r <= lr_nxt; // [R7]
         dout_r <= tx_bit_nxt; // [R7]
      end
   end

   // ****************************************************************
   // Receive deserialiser
   // ****************************************************************
   assign rx_map = bit_map(slot_r, slots_cur, cfg_fmt_r); // [R11]
   assign rx_left = is_left(slot_r, slots_cur);
   assign frame_end = rise_evt && (slot_r == slots_cur - 1'b1);

   always_comb begin
      cap_l = rx_l_sh_r;
      cap_r = rx_r_sh_r;
      if (rx_map[5]) begin // [R12]
         if (rx_left) begin
            cap_l[rx_map[4:0]] = din_s2_r;
         end else begin
            cap_r[rx_map[4:0]] = din_s2_r;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_l_sh_r <= '0;
         rx_r_sh_r <= '0;
         rx_l_r <= '0;
         rx_rt_r <= '0;
      end else if (frame_end) begin
         rx_l_r <= cap_l; // [R3]
         rx_rt_r <= cap_r;
         rx_l_sh_r <= '0;
         rx_r_sh_r <= '0;
      end else if (rise_evt) begin
         rx_l_sh_r <= cap_l; // [R8]
         rx_r_sh_r <= cap_r;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_valid_r <= 1'h0;
      end else begin
         rx_valid_r <= frame_end; // [R10]
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign aux_bit_clock_out = bclk_r;
   assign aux_frame_select_out = lr_r;
   assign aux_serial_out = dout_r;
   assign tx_ready_out = tx_s.in_ready;
   assign rx_left_out = rx_l_r;
   assign rx_right_out = rx_rt_r;
   assign rx_valid_out = rx_valid_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);
   a_clk_keeps_running: assert property ( // [R1]
      $changed(aux_bit_clock_out) |-> ##[1:512] $changed(aux_bit_clock_out))
      else $error("bit clock stopped");
   a_frame_wraps_rate: assert property ( // [R2]
      (fall_evt && slot_r == slots_cur - 1'b1) |=> (slot_r == '0))
      else $error("frame length does not follow rate field");
   a_rx_frame_done: assert property ( // [R3]
      rx_valid_out |-> $past(rise_evt) && $past(slot_r) == $past(slots_cur)
      - 1'b1)
      else $error("receive word not at frame end");
   a_lr_transitions: assert property ( // [R5]
      $changed(aux_frame_select_out) |->
      (slot_r == '0 || slot_r == (slots_cur >> 1)))
      else $error("framing edge off the channel boundary");
   a_lr_on_fall: assert property ( // [R7]
      $changed(aux_frame_select_out) |-> $fell(aux_bit_clock_out))
      else $error("framing changed away from falling edge");
   a_dout_on_fall: assert property ( // [R7]
      $changed(aux_serial_out) |-> $fell(aux_bit_clock_out))
      else $error("data changed away from falling edge");
   a_msb_lj_first: assert property ( // [R11]
      (load_evt && fmt_sel == apcm_pkg::FMT_LJ) |=>
      (aux_serial_out == tx_hold_r[apcm_pkg::WORD_W-1]))
      else $error("left-justified MSB not at frame start");
   a_msb_i2s_late: assert property ( // [R11]
      (fall_evt && slot_r == '0 && cfg_fmt_r == apcm_pkg::FMT_I2S) |->
      !aux_serial_out ##1 (aux_serial_out == tx_hold_r[apcm_pkg::WORD_W-1]))
      else $error("I2S MSB not one clock after framing edge");
   a_zero_pad: assert property ( // [R12]
      (fall_evt && !tx_map[5]) |=> !aux_serial_out)
      else $error("non-zero bit beyond sample width");
   a_pop_at_frame: assert property ( // [R10]
      (load_evt && tx_s.out_valid) |=> (tx_hold_r == $past(tx_s.out_data)))
      else $error("FIFO word not loaded at frame start");
   c_lj_frame: cover property (
      load_evt && fmt_sel == apcm_pkg::FMT_LJ && slots_sel ==
      apcm_pkg::SLOTS_128);
   c_i2s_frame: cover property (
      load_evt && fmt_sel == apcm_pkg::FMT_I2S && slots_sel ==
      apcm_pkg::SLOTS_64);
   c_rx_word: cover property (rx_valid_out);
   c_fifo_full: cover property (!tx_ready_out);

endmodule : apcm_port

// *** pkg/apcm_pkg.sv ***
/*
 * Shared constants and types of the auxiliary PCM audio port.
 * Assumes a single 250 MHz core clock that drives all port logic.
 */
package apcm_pkg;

   // ****************************************************************
   // Clock and sample rate figures
   // ****************************************************************
   localparam int MCLK_HZ = 250_000_000;
   localparam int FS_MIN_KHZ = 16;
   localparam int FS_MAX_KHZ = 48;
   // Fastest bit clock is 128 Fs at 48 kHz, slowest 32 Fs at 16 kHz
   localparam int BCLK_HALF_MIN_CYC = MCLK_HZ / (2 * 128 * FS_MAX_KHZ * 1000);
   localparam int BCLK_HALF_MAX_CYC = MCLK_HZ / (2 * 32 * FS_MIN_KHZ * 1000);
   localparam int DIV_W = $clog2(BCLK_HALF_MAX_CYC + 1);

   // ****************************************************************
   // Control field, slot counts and sample layout
   // ****************************************************************
   localparam int CTRL_RATE_LSB = 0;
   localparam int CTRL_RATE_MSB = 1;
   localparam int SLOT_W = 8;
   localparam logic [SLOT_W-1:0] SLOTS_32 = 8'h20;
   localparam logic [SLOT_W-1:0] SLOTS_64 = 8'h40;
   localparam logic [SLOT_W-1:0] SLOTS_128 = 8'h80;
   localparam logic [SLOT_W-1:0] SLOT_RST = 8'hFF;
   localparam int SAMPLE_W = 20;
   localparam int WORD_W = 2 * SAMPLE_W;
   localparam logic [4:0] WIDTH_I2S = 5'h12;
   localparam logic [4:0] WIDTH_LJ = 5'h14;
   localparam logic [4:0] MSB_IDX = 5'h13;
   localparam int FIFO_DEPTH = 4;

   typedef enum logic [1:0] {
      RATE_32FS = 2'h0,
      RATE_64FS = 2'h1,
      RATE_128FS = 2'h2
   } apcm_rate_t;

   typedef enum logic {
      FMT_I2S = 1'h0,
      FMT_LJ = 1'h1
   } apcm_fmt_t;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic BCLK_RST = 1'h1;
   localparam logic [1:0] RATE_RST = 2'h1;
   localparam logic FMT_RST = 1'h0;

endpackage : apcm_pkg

// *** pkg/apcm_stream_if.sv ***
/*
 * Valid/ready word stream between the port and its transmit FIFO.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface apcm_stream_if #(parameter int W = 40);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;

   modport fifo_side (
      input in_valid, in_data, out_ready,
      output in_ready, out_valid, out_data
   );
   modport user_side (
      output in_valid, in_data, out_ready,
      input in_ready, out_valid, out_data
   );
endinterface : apcm_stream_if

// *** hw/apcm_fifo.sv ***
/*
 * Small synchronous FIFO with registered storage and registered ready.
 * Assumes DEPTH is at least two and both sides share mclk_in.
 */
`timescale 1ns/100ps
module apcm_fifo #(
   parameter int W = 40,
   parameter int DEPTH = 4
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   apcm_stream_if.fifo_side s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic in_ready_r;
   logic push;
   logic pop;

   assign push = s.in_valid && in_ready_r;
   assign pop = s.out_ready && (cnt_r != '0);
   assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   assign s.in_ready = in_ready_r;
   assign s.out_valid = (cnt_r != '0);
   assign s.out_data = mem_r[rd_ptr_r];

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= s.in_data;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
         in_ready_r <= 1'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_nxt;
         in_ready_r <= (cnt_nxt != FULL_CNT);
      end
   end

endmodule : apcm_fifo

// *** bench/apcm_codec_model.sv ***
/*
 * Behavioural far-end codec for the auxiliary PCM port: slave to the
 * port's bit clock and framing, sends one fixed stereo pair each frame
 * and decodes the pair that the port sends.
 * Assumes the port settles its outputs well within 1 ns of a bclk edge.
 */
`timescale 1ns/100ps
module apcm_codec_model (
   input wire logic bclk_in,
   input wire logic fs_in,
   input wire logic sdo_in,
   input wire logic fmt_in,
   input wire logic [19:0] src_l_in,
   input wire logic [19:0] src_r_in,
   output logic sdi_out,
   output logic [19:0] got_l_out,
   output logic [19:0] got_r_out,
   output int frames_out,
   output int zero_err_out
);
   // ****************************************************************
   // Slot tracking and transmit
   // ****************************************************************
   int p = 0;
   int k = 0;
   int wid = 20;
   logic fs_q = 1'h0;
   logic left;
   logic [19:0] cap_l = 20'h00000;
   logic [19:0] cap_r = 20'h00000;

   assign left = fmt_in ? fs_in : !fs_in;

   initial begin
      sdi_out = 1'h0;
      got_l_out = 20'h00000;
      got_r_out = 20'h00000;
      frames_out = 0;
      forever begin
         @(negedge bclk_in);
         // Let the port's same-edge updates land first
         #1;
         if (fs_in != fs_q) begin
            p = 0;
            if (left) begin
               got_l_out = cap_l;
               got_r_out = cap_r;
               frames_out++;
               cap_l = 20'h00000;
               cap_r = 20'h00000;
            end
         end else begin
            p++;
         end
         fs_q = fs_in;
         k = fmt_in ? p : p - 1;
         wid = fmt_in ? 20 : 18;
         if (k >= 0 && k < wid) begin
            sdi_out = left ? src_l_in[19-k] : src_r_in[19-k];
         end else begin
            // Unused slot: line is not held, so toggle it
            sdi_out = !sdi_out;
         end
      end
   end

   // ****************************************************************
   // Receive
   // ****************************************************************
   initial begin
      zero_err_out = 0;
      forever begin
         @(posedge bclk_in);
         if (k >= 0 && k < wid) begin
            if (left) begin
               cap_l[19-k] = sdo_in;
            end else begin
               cap_r[19-k] = sdo_in;
            end
         end else if (sdo_in !== 1'h0) begin
            zero_err_out++;
         end
      end
   end
endmodule : apcm_codec_model

// *** bench/apcm_port_tb.sv ***
/*
 * Self-checking bench of the auxiliary PCM port with a far-end codec
 * model on its serial pins.
 * Assumes the port and package as delivered, bit clock half period of
 * 20 core cycles (160 ns bit clock).
 */
`timescale 1ns/100ps
module apcm_port_tb;
   // ****************************************************************
   // Clock, reset and connections
   // ****************************************************************
   localparam int HALF = 20;
   logic mclk = 1'h0;
   logic reset_n = 1'h0;
   logic [1:0] rate = 2'h1;
   logic fmt = 1'h0;
   logic [apcm_pkg::DIV_W-1:0] half = 8'h14;
   logic [19:0] tx_l = 20'h00000;
   logic [19:0] tx_r = 20'h00000;
   logic [19:0] src_l = 20'h00000;
   logic [19:0] src_r = 20'h00000;
   logic tx_valid = 1'h0;
   logic tx_ready, rx_valid, sdi, bclk, fs, sdo, bclk_q, fs_q, sdo_q;
   logic [19:0] rx_l, rx_r, got_l, got_r;
   int frames, zero_err;
   int cyc = 0;
   int tf = 0;
   int tp = 0;
   int r7_bad = 0;
   int miscompares = 0;
   int n_tests = 0;

   initial begin
      forever #2 mclk = ~mclk;
   end

   apcm_port DUT (
      .mclk_in(mclk),
      .reset_n_in(reset_n),
      .aux_port_control_reg_in(rate),
      .aux_format_in(fmt),
      .bclk_half_in(half),
      .tx_left_in(tx_l),
      .tx_right_in(tx_r),
      .tx_valid_in(tx_valid),
      .tx_ready_out(tx_ready),
      .rx_left_out(rx_l),
      .rx_right_out(rx_r),
      .rx_valid_out(rx_valid),
      .aux_serial_in(sdi),
      .aux_bit_clock_out(bclk),
      .aux_frame_select_out(fs),
      .aux_serial_out(sdo)
   );

   apcm_codec_model codec (
      .bclk_in(bclk),
      .fs_in(fs),
      .sdo_in(sdo),
      .fmt_in(fmt),
      .src_l_in(src_l),
      .src_r_in(src_r),
      .sdi_out(sdi),
      .got_l_out(got_l),
      .got_r_out(got_r),
      .frames_out(frames),
      .zero_err_out(zero_err)
   );

   // ****************************************************************
   // Edge monitor and timeout
   // ****************************************************************
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      bclk_q <= bclk;
      fs_q <= fs;
      sdo_q <= sdo;
      if (reset_n && cyc > 6 && (fs !== fs_q || sdo !== sdo_q) &&
          !(bclk_q === 1'h1 && bclk === 1'h0)) begin
         r7_bad <= r7_bad + 1;
      end
      if (cyc == 80000) begin
         miscompares = miscompares + 1;
         finish_test;
      end
   end

   // ****************************************************************
   // Compare and handshake tasks
   // ****************************************************************
   task check(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t value got %h expected %h", $time, got, exp);
      end
   endtask : check

   task check_n(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         miscompares++;
         $display("BAD %0t count got %0d expected %0d", $time, got, exp);
      end
   endtask : check_n

   task finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   task wait_model;
      int nf;
      nf = frames;
      @(posedge mclk iff frames != nf);
      tp = tf;
      tf = cyc;
   endtask : wait_model

   task push(input logic [19:0] l, input logic [19:0] r);
      tx_l <= l;
      tx_r <= r;
      tx_valid <= 1'h1;
      @(posedge mclk iff tx_ready === 1'h1);
   endtask : push

   // New setting is taken at a frame start; let one whole frame pass
   task settle(input logic [1:0] r, input logic f);
      rate <= r;
      fmt <= f;
      @(posedge mclk iff rx_valid === 1'h1);
      @(posedge mclk);
      check({39'h0, rx_valid}, 40'h0);
      @(posedge mclk iff rx_valid === 1'h1);
      wait_model;
   endtask : settle

   task duplex(input int n, input logic [19:0] m, input logic [19:0] wl,
               input logic [19:0] wr, input logic [19:0] sl,
               input logic [19:0] sr);
      int z0;
      src_l <= sl;
      src_r <= sr;
      push(wl, wr);
      tx_valid <= 1'h0;
      wait_model;
      z0 = zero_err;
      wait_model;
      check({got_l, got_r}, {wl & m, wr & m});
      check({rx_l, rx_r}, {sl & m, sr & m});
      check_n(tf - tp, n * 2 * HALF);
      check_n(zero_err - z0, 0);
   endtask : duplex

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_reset;
      check({36'h0, tx_ready, bclk, fs, sdo}, 40'h4);
      @(posedge mclk);
      reset_n <= 1'h1;
      repeat (2) @(posedge mclk);
      check({39'h0, tx_ready}, 40'h1);
   endtask : t_reset

   task t_i2s;
      settle(2'h1, 1'h0);
      duplex(64, 20'hFFFFC, 20'hC3A5F, 20'h3C5A1, 20'h9E7B2, 20'h61485);
      // Spare rate code runs at 64 Fs
      settle(2'h3, 1'h0);
      wait_model;
      check_n(tf - tp, 64 * 2 * HALF);
   endtask : t_i2s

   task t_lj;
      settle(2'h2, 1'h1);
      duplex(128, 20'hFFFFF, 20'h8F00D, 20'h1234B, 20'hE0071, 20'h5AA5F);
   endtask : t_lj

   task t_fifo;
      int i;
      logic [19:0] el, er;
      settle(2'h0, 1'h1);
      for (i = 0; i < 4; i++) begin
         push(20'hA5A5F ^ 20'(i << 4), 20'h3C3CF ^ 20'(i << 8));
      end
      tx_valid <= 1'h0;
      repeat (2) @(posedge mclk);
      check({39'h0, tx_ready}, 40'h0);
      tx_l <= 20'hFFFFF;
      tx_r <= 20'hFFFFF;
      tx_valid <= 1'h1;
      repeat (3) @(posedge mclk);
      tx_valid <= 1'h0;
      wait_model;
      check({got_l, got_r}, 40'h0);
      for (i = 0; i < 4; i++) begin
         wait_model;
         el = (20'hA5A5F ^ 20'(i << 4)) & 20'hFFFF0;
         er = (20'h3C3CF ^ 20'(i << 8)) & 20'hFFFF0;
         check({got_l, got_r}, {el, er});
      end
      wait_model;
      check({got_l, got_r}, 40'h0);
      check({39'h0, tx_ready}, 40'h1);
      check_n(tf - tp, 32 * 2 * HALF);
   endtask : t_fifo

   initial begin
      repeat (3) @(posedge mclk);
      t_reset;
      t_i2s;
      t_lj;
      t_fifo;
      check_n(r7_bad, 0);
      finish_test;
   end
endmodule : apcm_port_tb
